// ===== rtl/ppf_pin_irq_flags.sv
// ppf_pin_irq_flags: pending flags, edge select and request enables for
// three general purpose input ports.
// assumes pins are asynchronous, usb_resume_evt comes from core_clk logic,
// and software uses the plain register port with read data one cycle later.
//
// How it works
// - port0 flags: one pending bit per input
// - flags clear on written zero, reset zero
// - usb variant: bit7 resume, bit6 unused
// - port1 flags: eight pending bits
// - port2 flags bits 4:0, upper read zero
// - control bit5 enables port2 requests
// - control bit4 enables port0 upper requests
// - control bit3 enables port0 lower requests
// - control bit2 picks port2 edge polarity
// - control bit1 picks port1 edge polarity
// - control bit0 picks port0 edge polarity
// - per-input request mask for port1
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
module ppf_pin_irq_flags #(
  parameter bit USB_CAPABLE = 1'b0  // 1: port0 bit7 carries usb resume
) (
  input  wire logic       core_clk,        // system clock, 25 MHz
  input  wire logic       rst_n,           // synchronous reset, active low
  input  wire logic [7:0] reg_addr,        // register address
  input  wire logic [7:0] reg_wdata,       // register write data
  input  wire logic       reg_wr,          // write strobe
  input  wire logic       reg_rd,          // read strobe
  output logic      [7:0] reg_rdata,       // read data, cycle after strobe
  input  wire logic [7:0] port0_pin,       // port 0 input pins
  input  wire logic [7:0] port1_pin,       // port 1 input pins
  input  wire logic [4:0] port2_pin,       // port 2 input pins
  input  wire logic       usb_resume_evt,  // resume during suspend, level
  output logic            port0_irq_req,   // port 0 request to irq control
  output logic            port1_irq_req,   // port 1 request to irq control
  output logic            port2_irq_req    // port 2 request to irq control
);

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  logic [7:0] p0_flags_reg;
  logic [7:0] p1_flags_reg;
  logic [4:0] p2_flags_reg;
  logic [6:0] ctrl_reg;
  logic [7:0] p1_mask_reg;
  logic [7:0] p0_prev_reg;
  logic [7:0] p1_prev_reg;
  logic [4:0] p2_prev_reg;
  logic [1:0] arm_cnt_reg;
  logic [7:0] p0_sync;
  logic [7:0] p1_sync;
  logic [4:0] p2_sync;
  logic [7:0] p0_src;
  logic [7:0] p0_impl;
  logic       armed;
  logic       wr_p0, wr_p1, wr_p2, wr_ctrl, wr_mask;
  logic       rd_p0, rd_p1, rd_p2, rd_ctrl, rd_mask;
  logic [7:0] p0_hit;
  logic [7:0] p1_hit;
  logic [4:0] p2_hit;
  logic [7:0] p2_edge8;  // port2 edges at function width, top bits padding
  logic [7:0] p0_flags_next;
  logic [7:0] p1_flags_next;
  logic [4:0] p2_flags_next;
  logic [7:0] rdata_next;
  logic [7:0] p0_en_vec;
  logic       p0_irq_next, p1_irq_next, p2_irq_next;

  generate
    if (USB_CAPABLE !== 1'b0 && USB_CAPABLE !== 1'b1) begin : g_bad_variant
      $error("ppf_pin_irq_flags: USB_CAPABLE must be 0 or 1");
    end
  endgenerate

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // address match qualified by a strobe, used for every read and write
  function automatic logic hit_at(input logic strobe, input logic [7:0] addr,
                                  input logic [7:0] offs);
    hit_at = strobe && (addr == offs);
  endfunction : hit_at

  // selected edge per bit: sel 0 rising, 1 falling
  function automatic logic [7:0] edge_of(input logic [7:0] now,
                                         input logic [7:0] was,
                                         input logic sel);
    edge_of = sel ? (was & ~now) : (now & ~was);
  endfunction : edge_of

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  ppf_sync #(.WIDTH(ppf_pkg::P0_W)) u_sync_p0 (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .async_in (port0_pin),
    .sync_out (p0_sync)
  );

  ppf_sync #(.WIDTH(ppf_pkg::P1_W)) u_sync_p1 (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .async_in (port1_pin),
    .sync_out (p1_sync)
  );

  ppf_sync #(.WIDTH(ppf_pkg::P2_W)) u_sync_p2 (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .async_in (port2_pin),
    .sync_out (p2_sync)
  );

  // ----------------------------------------------------------------------
  // port 0 source layout
  // ----------------------------------------------------------------------
  // resume is internal and already on core_clk, so it skips the syncs;
  // it shares the port0 edge select, which is why software keeps it rising
  assign p0_src = USB_CAPABLE ? {usb_resume_evt, 1'b0, p0_sync[5:0]}
                              : p0_sync;
  assign p0_impl = USB_CAPABLE ? ppf_pkg::P0_IMPL_USB
                               : ppf_pkg::P0_IMPL_PLAIN;

  // ----------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------
  assign wr_p0   = hit_at(reg_wr, reg_addr, ppf_pkg::ADDR_P0_FLAGS);
  assign wr_p1   = hit_at(reg_wr, reg_addr, ppf_pkg::ADDR_P1_FLAGS);
  assign wr_p2   = hit_at(reg_wr, reg_addr, ppf_pkg::ADDR_P2_FLAGS);
  assign wr_ctrl = hit_at(reg_wr, reg_addr, ppf_pkg::ADDR_CTRL);
  assign wr_mask = hit_at(reg_wr, reg_addr, ppf_pkg::ADDR_P1_MASK);
  assign rd_p0   = hit_at(reg_rd, reg_addr, ppf_pkg::ADDR_P0_FLAGS);
  assign rd_p1   = hit_at(reg_rd, reg_addr, ppf_pkg::ADDR_P1_FLAGS);
  assign rd_p2   = hit_at(reg_rd, reg_addr, ppf_pkg::ADDR_P2_FLAGS);
  assign rd_ctrl = hit_at(reg_rd, reg_addr, ppf_pkg::ADDR_CTRL);
  assign rd_mask = hit_at(reg_rd, reg_addr, ppf_pkg::ADDR_P1_MASK);

  // ----------------------------------------------------------------------
  // edge detection
  // ----------------------------------------------------------------------
  // edges are ignored until the sync pipeline and history hold real pin
  // levels, else a pin high at reset would fake a rising edge
  assign armed  = (arm_cnt_reg == ppf_pkg::ARM_CYCLES);
  assign p0_hit = armed ? edge_of(p0_src, p0_prev_reg,
                                  ctrl_reg[ppf_pkg::CTRL_P0_EDGE]) : 8'h00;
  assign p1_hit = armed ? edge_of(p1_sync, p1_prev_reg,
                                  ctrl_reg[ppf_pkg::CTRL_P1_EDGE]) : 8'h00;
  assign p2_edge8 = edge_of({3'h0, p2_sync}, {3'h0, p2_prev_reg},
                            ctrl_reg[ppf_pkg::CTRL_P2_EDGE]);
  assign p2_hit   = armed ? p2_edge8[4:0] : 5'h00;

  // ----------------------------------------------------------------------
  // flag next state: written zero clears, written one keeps, set wins
  // ----------------------------------------------------------------------
  assign p0_flags_next = ((p0_flags_reg & (wr_p0 ? reg_wdata : 8'hFF))
                          | p0_hit) & p0_impl;
  assign p1_flags_next = (p1_flags_reg & (wr_p1 ? reg_wdata : 8'hFF))
                         | p1_hit;
  assign p2_flags_next = (p2_flags_reg & (wr_p2 ? reg_wdata[4:0] : 5'h1F))
                         | p2_hit;

  // ----------------------------------------------------------------------
  // request outputs: flags always record, enables only gate the request
  // ----------------------------------------------------------------------
  assign p0_en_vec = {{4{ctrl_reg[ppf_pkg::CTRL_P0_HI_EN]}},
                      {4{ctrl_reg[ppf_pkg::CTRL_P0_LO_EN]}}};
  assign p0_irq_next = |(p0_flags_reg & p0_en_vec);
  assign p1_irq_next = |(p1_flags_reg & p1_mask_reg);
  assign p2_irq_next = ctrl_reg[ppf_pkg::CTRL_P2_EN] && (|p2_flags_reg);

  // ----------------------------------------------------------------------
  // read mux; unmapped addresses return zero
  // ----------------------------------------------------------------------
  assign rdata_next = rd_p0   ? p0_flags_reg :
                      rd_p1   ? p1_flags_reg :
                      rd_p2   ? {3'h0, p2_flags_reg} :
                      rd_ctrl ? {1'b0, ctrl_reg} :
                      rd_mask ? p1_mask_reg :
                      ppf_pkg::RDATA_UNMAPPED;

  // ----------------------------------------------------------------------
  // flag registers
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      p0_flags_reg <= ppf_pkg::FLAGS_RST;
      p1_flags_reg <= ppf_pkg::FLAGS_RST;
      p2_flags_reg <= ppf_pkg::FLAGS_RST[4:0];
    end else begin
      p0_flags_reg <= p0_flags_next;
      p1_flags_reg <= p1_flags_next;
      p2_flags_reg <= p2_flags_next;
    end
  end

  // ----------------------------------------------------------------------
  // control, mask and edge history
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl_reg    <= ppf_pkg::CTRL_RST;
      p1_mask_reg <= ppf_pkg::MASK_RST;
      p0_prev_reg <= 8'h00;
      p1_prev_reg <= 8'h00;
      p2_prev_reg <= 5'h00;
      arm_cnt_reg <= 2'h0;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= reg_wdata[6:0];
      end
      if (wr_mask) begin
        p1_mask_reg <= reg_wdata;
      end
      p0_prev_reg <= p0_src;
      p1_prev_reg <= p1_sync;
      p2_prev_reg <= p2_sync;
      if (!armed) begin
        arm_cnt_reg <= arm_cnt_reg + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reg_rdata     <= 8'h00;
      port0_irq_req <= 1'b0;
      port1_irq_req <= 1'b0;
      port2_irq_req <= 1'b0;
    end else begin
      reg_rdata     <= rdata_next;
      port0_irq_req <= p0_irq_next;
      port1_irq_req <= p1_irq_next;
      port2_irq_req <= p2_irq_next;
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  a_p0_read_back: assert property (@(posedge core_clk) disable iff (!rst_n)
    rd_p0 |=> reg_rdata == $past(p0_flags_reg))
    else $error("port0 flag read wrong");

  a_zero_write_clears: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr_p1 && p1_hit == 8'h00) |=> p1_flags_reg == ($past(p1_flags_reg) & $past(reg_wdata)))
    else $error("port1 zero write did not clear");

  a_one_write_noset: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr_p2 && p2_hit == 5'h00 && p2_flags_reg == 5'h00) |=> p2_flags_reg == 5'h00)
    else $error("writing one set a port2 flag");

  a_spare_bit_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    (USB_CAPABLE && rd_p0) |=> !reg_rdata[ppf_pkg::P0_SPARE_BIT])
    else $error("usb variant spare bit read one");

  a_p1_read_back: assert property (@(posedge core_clk) disable iff (!rst_n)
    rd_p1 |=> reg_rdata == $past(p1_flags_reg))
    else $error("port1 flag read wrong");

  a_p2_upper_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    rd_p2 |=> reg_rdata[7:5] == 3'h0 && reg_rdata[4:0] == $past(p2_flags_reg))
    else $error("port2 read wrong or upper bits set");

  a_p2_enable_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
    !ctrl_reg[ppf_pkg::CTRL_P2_EN] |=> !port2_irq_req)
    else $error("port2 request while disabled");

  a_p0_upper_req: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ctrl_reg[ppf_pkg::CTRL_P0_HI_EN] && p0_flags_reg[7:4] != 4'h0) |=> port0_irq_req)
    else $error("port0 upper flag gave no request");

  a_p0_lower_req: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ctrl_reg[4:3] == 2'h1 && p0_flags_reg[3:0] == 4'h0) |=> !port0_irq_req)
    else $error("port0 request without enabled flag");

  a_p2_edge_sets: assert property (@(posedge core_clk) disable iff (!rst_n)
    (armed && !ctrl_reg[2] && p2_sync[0] && !p2_prev_reg[0]) |=> p2_flags_reg[0])
    else $error("port2 rising edge missed");

  a_p1_fall_sets: assert property (@(posedge core_clk) disable iff (!rst_n)
    (armed && ctrl_reg[1] && !p1_sync[0] && p1_prev_reg[0]) |=> p1_flags_reg[0])
    else $error("port1 falling edge missed");

  a_p0_rise_only: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!ctrl_reg[0] && !wr_p0 && p0_flags_reg[0] == 1'b0 && !(p0_src[0] && !p0_prev_reg[0]))
      |=> !p0_flags_reg[0])
    else $error("port0 flag set without rising edge");

  // write, one quiet cycle, then read back: bit7 must come back zero
  a_ctrl_top_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_ctrl ##1 !wr_ctrl ##1 rd_ctrl |=> reg_rdata == ($past(reg_wdata, 3) & 8'h7F))
    else $error("control readback wrong");

  a_p1_mask_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
    (p1_flags_reg & p1_mask_reg) == 8'h00 |=> !port1_irq_req)
    else $error("port1 request from masked input");

  a_flag_sticky: assert property (@(posedge core_clk) disable iff (!rst_n)
    (p1_flags_reg[7] && !wr_p1) |=> p1_flags_reg[7])
    else $error("port1 flag dropped without clear");

endmodule : ppf_pin_irq_flags

// ===== rtl/ppf_pkg.sv
// ppf_pkg: register map, field positions, reset values and widths for the
// port pin interrupt flag block.
// assumes an 8-bit register port with byte-wide registers at these addresses.
package ppf_pkg;

  // ----------------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_P0_FLAGS = 8'h89;  // port0_pending_flags
  localparam logic [7:0] ADDR_P1_FLAGS = 8'h8A;  // port1_pending_flags
  localparam logic [7:0] ADDR_P2_FLAGS = 8'h8B;  // port2_pending_flags
  localparam logic [7:0] ADDR_CTRL     = 8'h8C;  // port_irq_edge_and_enable
  localparam logic [7:0] ADDR_P1_MASK  = 8'h8D;  // port1_pin_irq_mask

  // ----------------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------------
  localparam int REG_W = 8;  // register data width
  localparam int AW    = 8;  // register address width
  localparam int P0_W  = 8;  // port 0 inputs
  localparam int P1_W  = 8;  // port 1 inputs
  localparam int P2_W  = 5;  // port 2 inputs
  localparam int CTRL_W = 7;  // stored control bits 6:0, bit 7 reads zero

  // ----------------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------------
  localparam int CTRL_P0_EDGE  = 0;  // port0_edge_select
  localparam int CTRL_P1_EDGE  = 1;  // port1_edge_select
  localparam int CTRL_P2_EDGE  = 2;  // port2_edge_select
  localparam int CTRL_P0_LO_EN = 3;  // port0_lower_irq_enable
  localparam int CTRL_P0_HI_EN = 4;  // port0_upper_irq_enable
  localparam int CTRL_P2_EN    = 5;  // port2_irq_enable

  // ----------------------------------------------------------------------
  // port 0 layout in the usb variant and implemented-bit masks
  // ----------------------------------------------------------------------
  localparam int P0_RESUME_BIT = 7;  // usb resume during suspend
  localparam int P0_SPARE_BIT  = 6;  // unused in usb variant
  localparam logic [7:0] P0_IMPL_PLAIN = 8'hFF;
  localparam logic [7:0] P0_IMPL_USB   = 8'hBF;

  // ----------------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------------
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] MASK_RST  = 8'h00;
  localparam logic [6:0] CTRL_RST  = 7'h00;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
  // cycles after reset release before edges count: two sync stages + history
  localparam logic [1:0] ARM_CYCLES = 2'h3;

endpackage : ppf_pkg

// ===== rtl/ppf_sync.sv
// ppf_sync: two flip-flop synchroniser bank for asynchronous pin levels.
// assumes inputs are slow levels; each bit is synchronised on its own.
`timescale 1ns/1ps
module ppf_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             core_clk,  // system clock
  input  wire logic             rst_n,     // synchronous reset, active low
  input  wire logic [WIDTH-1:0] async_in,  // raw pin levels
  output logic      [WIDTH-1:0] sync_out   // levels on core_clk
);

  logic [WIDTH-1:0] meta_reg;  // first stage, read only by second stage

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("ppf_sync: WIDTH must be at least one");
    end
  endgenerate

  // ----------------------------------------------------------------------
  // two stages; only the second stage leaves this module
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : ppf_sync

// ===== verif/ppf_pin_irq_flags_tb.sv
// ppf_pin_irq_flags_tb: register and pin tests for the flag block.
// assumes ppf_pkg, both variants of the block and ppf_pin_model.
`timescale 1ns/1ps
module ppf_pin_irq_flags_tb;
  logic       core_clk;
  logic       rst_n;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] rdata_plain;
  logic [7:0] rdata_usb;
  logic [7:0] port0_pin;
  logic [7:0] port1_pin;
  logic [4:0] port2_pin;
  logic       usb_resume_evt;
  logic [2:0] req;
  logic [2:0] req_usb;
  int         fails;
  int         samples_checked;
  int         cycles;
  logic [7:0] vp;
  logic [7:0] vu;

  // ----------------------------------------------------------------------
  // clock, parts and timeout
  // ----------------------------------------------------------------------
  initial core_clk = 1'b0;
  always #20 core_clk = ~core_clk;

  ppf_pin_model i_ppf_pin_model (.core_clk(core_clk), .port0_pin(port0_pin),
    .port1_pin(port1_pin), .port2_pin(port2_pin), .usb_resume_evt(usb_resume_evt));

  ppf_pin_irq_flags #(.USB_CAPABLE(1'b0)) i_ppf_pin_irq_flags (.core_clk(core_clk),
    .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(rdata_plain), .port0_pin(port0_pin),
    .port1_pin(port1_pin), .port2_pin(port2_pin), .usb_resume_evt(usb_resume_evt),
    .port0_irq_req(req[0]), .port1_irq_req(req[1]), .port2_irq_req(req[2]));

  // usb variant shares bus and pins; judged on read data and requests
  ppf_pin_irq_flags #(.USB_CAPABLE(1'b1)) i_ppf_pin_irq_flags_usb (.core_clk(core_clk),
    .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(rdata_usb), .port0_pin(port0_pin),
    .port1_pin(port1_pin), .port2_pin(port2_pin), .usb_resume_evt(usb_resume_evt),
    .port0_irq_req(req_usb[0]), .port1_irq_req(req_usb[1]), .port2_irq_req(req_usb[2]));

  // the whole run needs well under a thousand cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // one-cycle write strobe, released at the next edge
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= addr;
    reg_wdata <= data;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic expect_reg(input logic [7:0] addr, input logic [7:0] ep,
                            input logic [7:0] eu);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= addr;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1;
    vp = rdata_plain;
    vu = rdata_usb;
    check($sformatf("plain reg %h", addr), vp, ep);
    check($sformatf("usb reg %h", addr), vu, eu);
  endtask : expect_reg

  // requests are registered one cycle behind flags and enables
  task automatic chk_req(input logic [2:0] exp);
    repeat (3) @(posedge core_clk);
    #1;
    check("irq requests", {5'h00, req}, {5'h00, exp});
    check("usb irq requests", {5'h00, req_usb}, {5'h00, exp});
  endtask : chk_req

  task automatic clear_flags();
    wr(ppf_pkg::ADDR_P0_FLAGS, 8'h00);
    wr(ppf_pkg::ADDR_P1_FLAGS, 8'h00);
    wr(ppf_pkg::ADDR_P2_FLAGS, 8'h00);
  endtask : clear_flags

  // pins need two sync stages and an edge stage before the flag shows
  task automatic pins(input logic [7:0] p0, input logic [7:0] p1,
                      input logic [4:0] p2, input logic usb);
    i_ppf_pin_model.drive(p0, p1, p2, usb);
    repeat (6) @(posedge core_clk);
  endtask : pins

  // ----------------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------------
  initial begin
    rst_n     = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    expect_reg(ppf_pkg::ADDR_P0_FLAGS, 8'h00, 8'h00);
    expect_reg(ppf_pkg::ADDR_P1_FLAGS, 8'h00, 8'h00);
    expect_reg(ppf_pkg::ADDR_P2_FLAGS, 8'h00, 8'h00);
    expect_reg(ppf_pkg::ADDR_CTRL, 8'h00, 8'h00);
    expect_reg(ppf_pkg::ADDR_P1_MASK, 8'h00, 8'h00);
    wr(ppf_pkg::ADDR_CTRL, 8'hFF);
    expect_reg(ppf_pkg::ADDR_CTRL, 8'h7F, 8'h7F);
    wr(ppf_pkg::ADDR_P1_MASK, 8'hA5);
    expect_reg(ppf_pkg::ADDR_P1_MASK, 8'hA5, 8'hA5);
    wr(8'h8E, 8'hFF);
    expect_reg(8'h8E, 8'h00, 8'h00);
    wr(ppf_pkg::ADDR_CTRL, 8'h00);
    wr(ppf_pkg::ADDR_P1_MASK, 8'h00);
    // rising edges with every enable off
    pins(8'hFF, 8'hFF, 5'h1F, 1'b0);
    expect_reg(ppf_pkg::ADDR_P0_FLAGS, 8'hFF, 8'h3F);
    expect_reg(ppf_pkg::ADDR_P1_FLAGS, 8'hFF, 8'hFF);
    expect_reg(ppf_pkg::ADDR_P2_FLAGS, 8'h1F, 8'h1F);
    chk_req(3'b000);
    wr(ppf_pkg::ADDR_CTRL, 8'h38);
    chk_req(3'b101);
    wr(ppf_pkg::ADDR_P1_MASK, 8'h01);
    chk_req(3'b111);
    wr(ppf_pkg::ADDR_P1_FLAGS, 8'hFE);
    expect_reg(ppf_pkg::ADDR_P1_FLAGS, 8'hFE, 8'hFE);
    chk_req(3'b101);
    wr(ppf_pkg::ADDR_P0_FLAGS, 8'hFF);
    expect_reg(ppf_pkg::ADDR_P0_FLAGS, 8'hFF, 8'h3F);
    wr(ppf_pkg::ADDR_P0_FLAGS, 8'h0F);
    expect_reg(ppf_pkg::ADDR_P0_FLAGS, 8'h0F, 8'h0F);
    wr(ppf_pkg::ADDR_CTRL, 8'h10);
    chk_req(3'b000);
    wr(ppf_pkg::ADDR_CTRL, 8'h08);
    chk_req(3'b001);
    wr(ppf_pkg::ADDR_P2_FLAGS, 8'hE0);
    expect_reg(ppf_pkg::ADDR_P2_FLAGS, 8'h00, 8'h00);
    wr(ppf_pkg::ADDR_P2_FLAGS, 8'hFF);
    expect_reg(ppf_pkg::ADDR_P2_FLAGS, 8'h00, 8'h00);
    // falling edges selected for all three ports
    wr(ppf_pkg::ADDR_CTRL, 8'h07);
    clear_flags();
    pins(8'h00, 8'h00, 5'h00, 1'b0);
    expect_reg(ppf_pkg::ADDR_P0_FLAGS, 8'hFF, 8'h3F);
    expect_reg(ppf_pkg::ADDR_P1_FLAGS, 8'hFF, 8'hFF);
    expect_reg(ppf_pkg::ADDR_P2_FLAGS, 8'h1F, 8'h1F);
    clear_flags();
    pins(8'hFF, 8'hFF, 5'h1F, 1'b0);
    expect_reg(ppf_pkg::ADDR_P0_FLAGS, 8'h00, 8'h00);
    expect_reg(ppf_pkg::ADDR_P1_FLAGS, 8'h00, 8'h00);
    expect_reg(ppf_pkg::ADDR_P2_FLAGS, 8'h00, 8'h00);
    // usb resume needs port 0 back on rising edges
    wr(ppf_pkg::ADDR_CTRL, 8'h00);
    pins(8'hFF, 8'hFF, 5'h1F, 1'b1);
    expect_reg(ppf_pkg::ADDR_P0_FLAGS, 8'h00, 8'h80);
    report_and_stop();
  end
endmodule : ppf_pin_irq_flags_tb

// ===== verif/ppf_pin_model.sv
// ppf_pin_model: drives the port pins and the usb resume level.
// assumes levels change only just after a rising core_clk edge.
`timescale 1ns/1ps
module ppf_pin_model (
  input  wire logic       core_clk,       // system clock
  output logic      [7:0] port0_pin,      // port 0 pin levels
  output logic      [7:0] port1_pin,      // port 1 pin levels
  output logic      [4:0] port2_pin,      // port 2 pin levels
  output logic            usb_resume_evt  // resume level
);
  // ----------------------------------------------------------------------
  // pin levels
  // ----------------------------------------------------------------------
  // all pins low at start, so the first rise is a clean edge
  initial begin
    port0_pin      = 8'h00;
    port1_pin      = 8'h00;
    port2_pin      = 5'h00;
    usb_resume_evt = 1'b0;
  end

  // levels are held, never pulsed: short pulses may slip past the syncs
  task automatic drive(input logic [7:0] p0, input logic [7:0] p1,
                       input logic [4:0] p2, input logic usb);
    @(posedge core_clk);
    port0_pin      <= p0;
    port1_pin      <= p1;
    port2_pin      <= p2;
    usb_resume_evt <= usb;
  endtask : drive
endmodule : ppf_pin_model
